/* verilog/proto_opt_pkg.sv */
package proto_opt_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TYPEB_TYPEF = 8'h07;
    localparam logic [7:0] IDX_STREAM = 8'h08;
    localparam logic [7:0] IDX_AUX = 8'h09;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_TYPEB_TYPEF = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STREAM = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_AUX = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h40;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TYPEB_TYPEF = 8'h00;
    localparam logic [7:0] RST_STREAM = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h04;
    localparam logic [7:0] STREAM_MASK = 8'h7F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TR1_LSB = 6;
    localparam int NO_SOF_BIT = 5;
    localparam int NO_EOF_BIT = 4;
    localparam int EOF_EXT_BIT = 3;
    localparam int PHASE_TOL_BIT = 2;
    localparam int PREAMBLE_LSB = 0;
    localparam int SCF_LSB = 5;
    localparam int SCP_LSB = 3;
    localparam int STX_LSB = 0;
    localparam int NO_CRC_BIT = 7;
    localparam int KEEP_CRC_BIT = 6;
    localparam int MOD_KIND_BIT = 5;
    localparam int FIELD_SENSE_BIT = 4;
    localparam int OOK_TRI_BIT = 3;
    localparam int RX_TOL_BIT = 2;
    localparam int FIELD_N_LSB = 0;

    // ------------------------------------------------------------
    // Command register bits
    // ------------------------------------------------------------
    localparam int CMD_SET_DEFAULT_BIT = 0;
    localparam int CMD_ANALOG_PRESET_BIT = 1;

    // ------------------------------------------------------------
    // Decoded timing values, in carrier periods (EOF limits in etu)
    // ------------------------------------------------------------
    localparam logic [7:0] TR1_80 = 8'h50;
    localparam logic [7:0] TR1_64 = 8'h40;
    localparam logic [7:0] TR1_32 = 8'h20;
    localparam logic [7:0] PREAMBLE_48 = 8'h30;
    localparam logic [7:0] PREAMBLE_STEP = 8'h10;
    localparam logic [7:0] DIV_128 = 8'h80;
    localparam logic [7:0] DIV_64 = 8'h40;
    localparam logic [7:0] DIV_32 = 8'h20;
    localparam logic [7:0] DIV_16 = 8'h10;
    localparam logic [3:0] EOF_MAX_NORMAL = 4'hB;
    localparam logic [3:0] EOF_MAX_EXT = 4'hC;
    localparam logic [3:0] EOF_MIN = 4'hA;

    // ------------------------------------------------------------
    // Bit-rate codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_128 = 2'b00,
        RATE_64 = 2'b01,
        RATE_32 = 2'b10,
        RATE_16 = 2'b11
    } rate_type;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

/* verilog/option_decode.sv */
`timescale 1ns/10ps
module option_decode (
    // Raw register contents
    input wire logic [7:0] typeb_typef,
    input wire logic [7:0] stream,
    input wire logic [7:0] aux,
    // Framing context
    input wire proto_opt_pkg::rate_type rx_rate,
    input wire logic bpsk_mode,
    input wire logic reqa_wupa_sent,
    input wire logic anticoll,
    // Decoded options
    output logic [7:0] tr1_min,
    output logic tr1_bad,
    output logic [3:0] eof_max,
    output logic [7:0] preamble_len,
    output logic [7:0] subcarrier_div,
    output logic stream_bad,
    output logic [3:0] pulse_count,
    output logic [7:0] tx_period_div,
    output logic crc_check,
    output logic crc_to_fifo
);
    logic [1:0] tr1;
    logic [1:0] scf;
    logic [1:0] scp;
    logic [2:0] stx;

    assign tr1 = typeb_typef[proto_opt_pkg::TR1_LSB +: 2];
    assign scf = stream[proto_opt_pkg::SCF_LSB +: 2];
    assign scp = stream[proto_opt_pkg::SCP_LSB +: 2];
    assign stx = stream[proto_opt_pkg::STX_LSB +: 3];

    always_comb begin
        tr1_bad = 1'b0;
        case (tr1)
            2'b00: tr1_min = proto_opt_pkg::TR1_80;
            2'b01: tr1_min = (rx_rate == proto_opt_pkg::RATE_128) ? proto_opt_pkg::TR1_64 : proto_opt_pkg::TR1_32;
            default: begin
                tr1_min = proto_opt_pkg::TR1_80;
                tr1_bad = 1'b1;
            end
        endcase
    end

    // The fastest rate (RATE_16) cannot tell 11 from 12 etu, so always widest window
    always_comb begin
        if (rx_rate == proto_opt_pkg::RATE_16) begin
            eof_max = proto_opt_pkg::EOF_MAX_EXT;
        end else if (typeb_typef[proto_opt_pkg::EOF_EXT_BIT]) begin
            eof_max = proto_opt_pkg::EOF_MAX_EXT;
        end else begin
            eof_max = proto_opt_pkg::EOF_MAX_NORMAL;
        end
    end

    assign preamble_len = proto_opt_pkg::PREAMBLE_48
        + 8'(typeb_typef[proto_opt_pkg::PREAMBLE_LSB +: 2]) * proto_opt_pkg::PREAMBLE_STEP;

    always_comb begin
        stream_bad = 1'b0;
        case (scf)
            2'b00: subcarrier_div = bpsk_mode ? proto_opt_pkg::DIV_16 : proto_opt_pkg::DIV_64;
            2'b01: begin
                subcarrier_div = proto_opt_pkg::DIV_32;
                stream_bad = bpsk_mode;
            end
            2'b10: begin
                subcarrier_div = proto_opt_pkg::DIV_16;
                stream_bad = bpsk_mode;
            end
            default: begin
                subcarrier_div = proto_opt_pkg::DIV_64;
                stream_bad = 1'b1;
            end
        endcase
        if (scp == 2'b00 && !bpsk_mode) begin
            stream_bad = 1'b1;
        end
        if (stx[2]) begin
            stream_bad = 1'b1;
        end
    end

    assign pulse_count = 4'(4'h1 << scp);
    assign tx_period_div = stx[2] ? proto_opt_pkg::DIV_128 : 8'(proto_opt_pkg::DIV_128 >> stx[1:0]);

    // Automatic no-CRC receive overrides the register bit
    assign crc_check = !(aux[proto_opt_pkg::NO_CRC_BIT] || reqa_wupa_sent || anticoll);
    assign crc_to_fifo = crc_check && aux[proto_opt_pkg::KEEP_CRC_BIT];
endmodule

/* verilog/hf_reader_protocol_option_regs.sv */
`timescale 1ns/10ps
module hf_reader_protocol_option_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [proto_opt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [proto_opt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Framing context from the protocol engine
    input wire proto_opt_pkg::rate_type rx_rate,
    input wire logic bpsk_mode,
    input wire logic reqa_wupa_sent,
    input wire logic anticoll,
    input wire logic ook_active,
    input wire logic preset_am,
    // Decoded framing options
    output logic [7:0] tr1_min,
    output logic accept_no_sof,
    output logic accept_no_eof,
    output logic [3:0] eof_min,
    output logic [3:0] eof_max,
    output logic phase_wide_tol,
    output logic [7:0] preamble_len,
    output logic [7:0] subcarrier_div,
    output logic [3:0] pulse_count,
    output logic [7:0] tx_period_div,
    output logic config_bad,
    output logic crc_check,
    output logic crc_to_fifo,
    output logic modulation_am,
    output logic field_detect_en,
    output logic antenna_driver_out_hiz,
    output logic bpsk_tolerant,
    output logic first_byte_tolerant,
    output logic [1:0] field_on_n
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] typeb_typef_options_r;
    logic [7:0] stream_mode_timing_r;
    logic [7:0] auxiliary_options_r;
    logic [7:0] aux_nxt;
    logic set_default_r;
    logic analog_preset_r;

    // ------------------------------------------------------------
    // Bus handshake state
    // ------------------------------------------------------------
    logic [proto_opt_pkg::ADDR_W-1:0] awaddr_r;
    logic aw_held_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic w_held_r;
    logic wr_fire;
    logic wr_hit;

    logic [7:0] d_tr1;
    logic d_tr1_bad;
    logic [3:0] d_eof_max;
    logic [7:0] d_pre;
    logic [7:0] d_scdiv;
    logic d_stream_bad;
    logic [3:0] d_pulses;
    logic [7:0] d_txdiv;
    logic d_crc_check;
    logic d_crc_fifo;
    logic ook_active_s1_r;
    logic ook_active_s2_r;

    // Registered readies, same timing as !held && !bvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = wr_fire && wstrb0_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= proto_opt_pkg::AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == proto_opt_pkg::ADDR_TYPEB_TYPEF || awaddr_r == proto_opt_pkg::ADDR_STREAM
                || awaddr_r == proto_opt_pkg::ADDR_AUX || awaddr_r == proto_opt_pkg::ADDR_CMD) begin
                s_axi_bresp <= proto_opt_pkg::AXI_OKAY;
            end else begin
                s_axi_bresp <= proto_opt_pkg::AXI_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command strobes
    // ------------------------------------------------------------
    // Self-clearing: a command acts for one cycle after the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_default_r <= 1'b0;
            analog_preset_r <= 1'b0;
        end else begin
            set_default_r <= wr_hit && awaddr_r == proto_opt_pkg::ADDR_CMD
                && wdata_r[proto_opt_pkg::CMD_SET_DEFAULT_BIT];
            analog_preset_r <= wr_hit && awaddr_r == proto_opt_pkg::ADDR_CMD
                && wdata_r[proto_opt_pkg::CMD_ANALOG_PRESET_BIT];
        end
    end

    // ------------------------------------------------------------
    // Option registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || set_default_r) begin
            typeb_typef_options_r <= proto_opt_pkg::RST_TYPEB_TYPEF;
        end else if (wr_hit && awaddr_r == proto_opt_pkg::ADDR_TYPEB_TYPEF) begin
            typeb_typef_options_r <= wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || set_default_r) begin
            stream_mode_timing_r <= proto_opt_pkg::RST_STREAM;
        end else if (wr_hit && awaddr_r == proto_opt_pkg::ADDR_STREAM) begin
            stream_mode_timing_r <= wdata_r & proto_opt_pkg::STREAM_MASK;
        end
    end

    // Preset loads the modulation kind; a later write may change it
    always_comb begin
        aux_nxt = auxiliary_options_r;
        if (analog_preset_r) begin
            aux_nxt[proto_opt_pkg::MOD_KIND_BIT] = preset_am;
        end
        if (wr_hit && awaddr_r == proto_opt_pkg::ADDR_AUX) begin
            aux_nxt = wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || set_default_r) begin
            auxiliary_options_r <= proto_opt_pkg::RST_AUX;
        end else begin
            auxiliary_options_r <= aux_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // Ready mirrors !rvalid but comes straight from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= proto_opt_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= proto_opt_pkg::AXI_OKAY;
            if (s_axi_araddr == proto_opt_pkg::ADDR_TYPEB_TYPEF) begin
                s_axi_rdata <= {24'h000000, typeb_typef_options_r};
            end else if (s_axi_araddr == proto_opt_pkg::ADDR_STREAM) begin
                s_axi_rdata <= {24'h000000, stream_mode_timing_r};
            end else if (s_axi_araddr == proto_opt_pkg::ADDR_AUX) begin
                s_axi_rdata <= {24'h000000, auxiliary_options_r};
            end else if (s_axi_araddr == proto_opt_pkg::ADDR_CMD) begin
                s_axi_rdata <= '0;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= proto_opt_pkg::AXI_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Option decode
    // ------------------------------------------------------------
    option_decode u_decode (
        .typeb_typef(typeb_typef_options_r),
        .stream(stream_mode_timing_r),
        .aux(auxiliary_options_r),
        .rx_rate(rx_rate),
        .bpsk_mode(bpsk_mode),
        .reqa_wupa_sent(reqa_wupa_sent),
        .anticoll(anticoll),
        .tr1_min(d_tr1),
        .tr1_bad(d_tr1_bad),
        .eof_max(d_eof_max),
        .preamble_len(d_pre),
        .subcarrier_div(d_scdiv),
        .stream_bad(d_stream_bad),
        .pulse_count(d_pulses),
        .tx_period_div(d_txdiv),
        .crc_check(d_crc_check),
        .crc_to_fifo(d_crc_fifo)
    );

    // Modulator activity is on another clock, synchronise first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ook_active_s1_r <= 1'b0;
            ook_active_s2_r <= 1'b0;
        end else begin
            ook_active_s1_r <= ook_active;
            ook_active_s2_r <= ook_active_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Registered option outputs
    // ------------------------------------------------------------
    // One cycle of latency after any register change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tr1_min <= proto_opt_pkg::TR1_80;
            accept_no_sof <= 1'b0;
            accept_no_eof <= 1'b0;
            eof_min <= proto_opt_pkg::EOF_MIN;
            eof_max <= proto_opt_pkg::EOF_MAX_NORMAL;
            phase_wide_tol <= 1'b0;
            preamble_len <= proto_opt_pkg::PREAMBLE_48;
            subcarrier_div <= proto_opt_pkg::DIV_64;
            pulse_count <= 4'h1;
            tx_period_div <= proto_opt_pkg::DIV_128;
            config_bad <= 1'b0;
            crc_check <= 1'b1;
            crc_to_fifo <= 1'b0;
        end else begin
            tr1_min <= d_tr1;
            accept_no_sof <= typeb_typef_options_r[proto_opt_pkg::NO_SOF_BIT];
            accept_no_eof <= typeb_typef_options_r[proto_opt_pkg::NO_EOF_BIT];
            eof_min <= proto_opt_pkg::EOF_MIN;
            eof_max <= d_eof_max;
            phase_wide_tol <= typeb_typef_options_r[proto_opt_pkg::PHASE_TOL_BIT];
            preamble_len <= d_pre;
            subcarrier_div <= d_scdiv;
            pulse_count <= d_pulses;
            tx_period_div <= d_txdiv;
            config_bad <= d_tr1_bad || d_stream_bad;
            crc_check <= d_crc_check;
            crc_to_fifo <= d_crc_fifo;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulation_am <= 1'b0;
            field_detect_en <= 1'b0;
            antenna_driver_out_hiz <= 1'b0;
            bpsk_tolerant <= 1'b0;
            first_byte_tolerant <= 1'b0;
            field_on_n <= 2'b00;
        end else begin
            modulation_am <= auxiliary_options_r[proto_opt_pkg::MOD_KIND_BIT];
            field_detect_en <= auxiliary_options_r[proto_opt_pkg::FIELD_SENSE_BIT];
            antenna_driver_out_hiz <= auxiliary_options_r[proto_opt_pkg::OOK_TRI_BIT]
                && !auxiliary_options_r[proto_opt_pkg::MOD_KIND_BIT] && ook_active_s2_r;
            bpsk_tolerant <= auxiliary_options_r[proto_opt_pkg::RX_TOL_BIT] && bpsk_mode
                && rx_rate == proto_opt_pkg::RATE_32;
            first_byte_tolerant <= auxiliary_options_r[proto_opt_pkg::RX_TOL_BIT] && !bpsk_mode
                && rx_rate == proto_opt_pkg::RATE_128;
            field_on_n <= auxiliary_options_r[proto_opt_pkg::FIELD_N_LSB +: 2];
        end
    end
endmodule

/* verification/proto_opt_assertions.sv */
`timescale 1ns/10ps
module proto_opt_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshake
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Context and options
    input wire proto_opt_pkg::rate_type rx_rate,
    input wire logic bpsk_mode,
    input wire logic reqa_wupa_sent,
    input wire logic anticoll,
    input wire logic ook_active,
    input wire logic [3:0] eof_max,
    input wire logic [7:0] preamble_len,
    input wire logic [3:0] pulse_count,
    input wire logic crc_check,
    input wire logic crc_to_fifo,
    input wire logic antenna_driver_out_hiz,
    input wire logic bpsk_tolerant
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_eoffast; (rx_rate == proto_opt_pkg::RATE_16)[*2] |-> eof_max == 4'hC; endproperty
    a_eoffast: assert property (p_eoffast) else $error("fast eof not widest");
    property p_pre; preamble_len inside {8'h30, 8'h40, 8'h50, 8'h60}; endproperty
    a_pre: assert property (p_pre) else $error("bad preamble");
    property p_pulse; $onehot(pulse_count); endproperty
    a_pulse: assert property (p_pulse) else $error("bad pulse count");
    property p_nocrc; (reqa_wupa_sent || anticoll)[*2] |-> !crc_check && !crc_to_fifo; endproperty
    a_nocrc: assert property (p_nocrc) else $error("crc not skipped");
    property p_keep; crc_to_fifo |-> crc_check; endproperty
    a_keep: assert property (p_keep) else $error("crc kept unchecked");
    property p_hiz; (!ook_active)[*4] |-> !antenna_driver_out_hiz; endproperty
    a_hiz: assert property (p_hiz) else $error("driver floats outside ook");
    property p_btol; (!bpsk_mode)[*2] |-> !bpsk_tolerant; endproperty
    a_btol: assert property (p_btol) else $error("bpsk tolerance off mode");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_hiz: cover property (antenna_driver_out_hiz);
endmodule

bind hf_reader_protocol_option_regs proto_opt_checker chk_i (.*);

/* verification/hf_reader_protocol_option_regs_bench.sv */
`timescale 1ns/10ps
module hf_reader_protocol_option_regs_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bpsk_mode, reqa_wupa_sent, anticoll, ook_active;
    logic preset_am, accept_no_sof, accept_no_eof, phase_wide_tol, config_bad, crc_check, crc_to_fifo, modulation_am;
    logic field_detect_en, antenna_driver_out_hiz, bpsk_tolerant, first_byte_tolerant;
    logic [7:0] s_axi_awaddr, s_axi_araddr, tr1_min, preamble_len, subcarrier_div, tx_period_div;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, eof_min, eof_max, pulse_count;
    logic [1:0] s_axi_bresp, s_axi_rresp, field_on_n;
    proto_opt_pkg::rate_type rx_rate;
    int bad_count = 0;
    int compares = 0;

    hf_reader_protocol_option_regs uut (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----
    // Bus tasks and checks
    // ----
    task close_out;
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] want);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom % 2);
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) break;
            s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, want);
    endtask

    task rd(input logic [7:0] ad, input logic [31:0] want, input logic [1:0] wresp);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom % 2);
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) break;
            s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, wresp);
        if (wresp == 2'b00) chk(s_axi_rdata, want);
    endtask

    function logic [7:0] tr1_of(input logic [1:0] c, input proto_opt_pkg::rate_type r);
        return (c == 2'b00) ? 8'h50 : ((r == proto_opt_pkg::RATE_128) ? 8'h40 : 8'h20);
    endfunction

    function logic [7:0] sub_of(input logic [1:0] c, input logic b);
        return b ? 8'h10 : (8'h40 >> c);
    endfunction

    // ----
    // Sequence
    // ----
    initial begin
        logic [7:0] tb, sb, ab;
        logic b;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {bpsk_mode, reqa_wupa_sent, anticoll, ook_active, preset_am} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        s_axi_wstrb = 4'hF;
        rx_rate = proto_opt_pkg::RATE_128;
        void'($urandom(13));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(proto_opt_pkg::ADDR_TYPEB_TYPEF, 32'h00, 2'b00);
        rd(proto_opt_pkg::ADDR_STREAM, 32'h00, 2'b00);
        rd(proto_opt_pkg::ADDR_AUX, 32'h04, 2'b00);
        wr(8'h28, 32'hFF, 2'b10);
        rd(8'h28, 32'h00, 2'b10);
        for (int i = 0; i < 60; i++) begin
            tb = 8'($urandom) & 8'h7F;
            b = 1'($urandom);
            sb = {1'b0, b ? 2'b00 : 2'($urandom % 3), b ? 2'($urandom) : 2'(1 + $urandom % 3), 1'b0, 2'($urandom)};
            ab = 8'($urandom);
            @(posedge aclk);
            rx_rate <= proto_opt_pkg::rate_type'(2'($urandom));
            bpsk_mode <= b;
            reqa_wupa_sent <= ($urandom % 4 == 0);
            anticoll <= ($urandom % 4 == 0);
            ook_active <= 1'($urandom);
            wr(proto_opt_pkg::ADDR_TYPEB_TYPEF, {24'h0, tb}, 2'b00);
            wr(proto_opt_pkg::ADDR_STREAM, {24'h0, sb}, 2'b00);
            wr(proto_opt_pkg::ADDR_AUX, {24'h0, ab}, 2'b00);
            repeat (4) @(posedge aclk);
            chk(tr1_min, tr1_of(tb[7:6], rx_rate));
            chk({accept_no_sof, accept_no_eof}, tb[5:4]);
            chk(eof_min, 4'hA);
            chk(eof_max, (tb[3] || rx_rate == proto_opt_pkg::RATE_16) ? 4'hC : 4'hB);
            chk(phase_wide_tol, tb[2]);
            chk(preamble_len, 8'h30 + {2'b00, tb[1:0], 4'h0});
            chk(subcarrier_div, sub_of(sb[6:5], b));
            chk(pulse_count, 4'h1 << sb[4:3]);
            chk(tx_period_div, 8'h80 >> sb[2:0]);
            chk(config_bad, 1'b0);
            chk(crc_check, !(ab[7] | reqa_wupa_sent | anticoll));
            chk(crc_to_fifo, !(ab[7] | reqa_wupa_sent | anticoll) & ab[6]);
            chk({modulation_am, field_detect_en}, ab[5:4]);
            chk(antenna_driver_out_hiz, ab[3] & !ab[5] & ook_active);
            chk({bpsk_tolerant, first_byte_tolerant}, {ab[2] & b & (rx_rate == proto_opt_pkg::RATE_32),
                ab[2] & !b & (rx_rate == proto_opt_pkg::RATE_128)});
            chk(field_on_n, ab[1:0]);
            rd(proto_opt_pkg::ADDR_STREAM, {24'h0, sb}, 2'b00);
        end
        wr(proto_opt_pkg::ADDR_TYPEB_TYPEF, 32'h80, 2'b00);
        repeat (4) @(posedge aclk);
        chk(config_bad, 1'b1);
        wr(proto_opt_pkg::ADDR_STREAM, 32'hFF, 2'b00);
        rd(proto_opt_pkg::ADDR_STREAM, 32'h7F, 2'b00);
        wr(proto_opt_pkg::ADDR_CMD, 32'h01, 2'b00);
        repeat (4) @(posedge aclk);
        rd(proto_opt_pkg::ADDR_TYPEB_TYPEF, 32'h00, 2'b00);
        rd(proto_opt_pkg::ADDR_STREAM, 32'h00, 2'b00);
        rd(proto_opt_pkg::ADDR_AUX, 32'h04, 2'b00);
        preset_am <= 1'b1;
        wr(proto_opt_pkg::ADDR_CMD, 32'h02, 2'b00);
        repeat (4) @(posedge aclk);
        chk(modulation_am, 1'b1);
        rd(proto_opt_pkg::ADDR_AUX, 32'h24, 2'b00);
        // Write with byte lane 0 off must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(proto_opt_pkg::ADDR_AUX, 32'hFF, 2'b00);
        s_axi_wstrb <= 4'hF;
        rd(proto_opt_pkg::ADDR_AUX, 32'h24, 2'b00);
        close_out;
    end

    // About 1300 cycles expected; a wide margin still ends a hung handshake
    initial begin
        #500000;
        bad_count++;
        close_out;
    end
endmodule
